// [bench/can_buf_regs_assertions.sv]
// Concurrent checks on the register port and the flag outputs.
// Assumes binding into can_buf_regs; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
// ----------
// Checker
// ----------
module can_buf_regs_checker
	import can_buf_pkg::*;
#(parameter int BUFS = NUM_BUFS) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic [BUFS-1:0] buffer_direction_flag,
	input wire logic [BUFS-1:0] outgoing_remote_flag
);
	// Shadow of the mode field; the port alone cannot tell which filters exist
	logic [1:0] mode_reg;
	always_ff @(posedge sys_clk or negedge reset_n)
		if (!reset_n) mode_reg <= MODE_RESET;
		else if (reg_write && reg_addr == MODE_ADDR) mode_reg <= reg_wdata[1:0];
	wire logic rd_len = reg_read && reg_addr < DIR_SEL_ADDR && reg_addr[3:0] == BUF_DLC_OFS;
	wire logic rd_flow = reg_read && reg_addr >= FLT_BASE && reg_addr[1:0] == 2'h1;
	wire logic rd_hi = reg_read && reg_addr >= 8'h98 && reg_addr < 8'hc0 && mode_reg[0] == mode_reg[1];
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	sequence dir_wr_s;
		reg_write && reg_addr == DIR_SEL_ADDR ##1 1'b1;
	endsequence
	dir_write_a: assert property (dir_wr_s |=>
		buffer_direction_flag == $past(reg_wdata[7:2], 2)) else $error("direction flags wrong");
	dir_reset_a: assert property ($rose(reset_n) |->
		buffer_direction_flag == '0) else $error("direction not cleared");
	dir_low_a: assert property (reg_read && reg_addr == DIR_SEL_ADDR |=>
		reg_rdata[1:0] == 2'h0) else $error("direction low bits set");
	len_zero_a: assert property (rd_len |=>
		reg_rdata[7] == 1'b0 && reg_rdata[5:4] == 2'h0) else $error("length spare bits set");
	flt_low_a: assert property (rd_flow |=>
		reg_rdata[4] == 1'b0 && reg_rdata[2] == 1'b0) else $error("filter low spare bits set");
	flt_absent_a: assert property (rd_hi |=>
		reg_rdata == 8'h00) else $error("absent filter readable");
	remote_dir_a: assert property (
		(outgoing_remote_flag & ~buffer_direction_flag) == '0) else $error("remote on receive buffer");
	rdata_idle_a: assert property (!$past(reg_read) |->
		reg_rdata == 8'h00) else $error("read data not idle");
endmodule : can_buf_regs_checker
bind can_buf_regs can_buf_regs_checker #(.BUFS(BUFS)) checker_i (.*);
`default_nettype wire

// [bench/can_engine_model.sv]
// Protocol engine model: stores received frames into the buffers.
// Assumes its task is called just after a rising clock edge.
`timescale 1ns/1ns
`default_nettype none
// ----------
// Receive side
// ----------
module can_engine_model (
	input wire logic sys_clk,
	output logic rx_store,
	output logic [2:0] rx_buf_index,
	output logic [28:0] rx_id,
	output logic rx_extended,
	output logic rx_remote,
	output logic [3:0] rx_length,
	output logic [63:0] rx_payload
);
	initial {rx_store, rx_buf_index, rx_id, rx_extended, rx_remote, rx_length, rx_payload} = '0;
	// Fields flip after the strobe, so a late capture cannot pass by luck
	task automatic store(input logic [2:0] b, input logic [28:0] id, input logic e,
		input logic r, input logic [3:0] l, input logic [63:0] p);
		{rx_buf_index, rx_id, rx_extended, rx_remote, rx_length, rx_payload} <= {b, id, e, r, l, p};
		rx_store <= 1'b1;
		@(posedge sys_clk) rx_store <= 1'b0;
		{rx_id, rx_extended, rx_remote, rx_length, rx_payload} <= {~id, ~e, ~r, ~l, ~p};
	endtask : store
endmodule : can_engine_model
`default_nettype wire

// [bench/tb_can_buf_regs.sv]
// Self-checking bench for the buffer and filter register block.
// Assumes the engine model for frames; the bench drives busy and filter-check inputs.
`timescale 1ns/1ns
`default_nettype none
// ----------
// Bench
// ----------
module tb_can_buf_regs import can_buf_pkg::*;;
	localparam logic [28:0] XID = 29'h1abcdef0;
	localparam logic [63:0] PAY = 64'h8877665544332211;
	localparam logic [7:0] FB [4] = '{XID[28:21], {XID[20:18], 3'h2, XID[17:16]},
		XID[15:8], XID[7:0]};
	logic sys_clk, reset_n, reg_write, reg_read, rx_store, rx_extended, rx_remote, check_extended;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [28:0] rx_id, check_id;
	logic [63:0] rx_payload;
	logic [5:0] tx_busy, buffer_direction_flag, outgoing_remote_flag;
	logic [3:0] rx_length;
	logic [2:0] rx_buf_index;
	logic [15:0] filter_hit;
	int err_count = 0, checked = 0;
	can_buf_regs dut (.*);
	can_engine_model pe (.*);
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		checked++;
		if (s !== e) $display("[ERR] %0t seen %h expected %h", $time, s, e);
		if (s !== e) err_count++;
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		{reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
		@(posedge sys_clk) reg_write <= 1'b0;
		// One idle edge, so back-to-back calls never drive the strobe twice at once
		@(posedge sys_clk);
	endtask : wr
	// Data sampled 1ns after the capturing edge, then realigned to an edge for the next access
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		{reg_addr, reg_read} <= {a, 1'b1};
		@(posedge sys_clk) reg_read <= 1'b0;
		#1 chk(reg_rdata, e);
		@(posedge sys_clk);
	endtask : rc
	task automatic give_verdict;
		if (err_count == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : give_verdict
	initial begin
		{reset_n, reg_addr, reg_wdata, reg_write, reg_read, tx_busy, check_id, check_extended} = '0;
		repeat (10) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		rc(DIR_SEL_ADDR, 8'h00);
		wr(MODE_ADDR, 8'h01);
		wr(DIR_SEL_ADDR, 8'hff);
		rc(DIR_SEL_ADDR, 8'hfc);
		wr(DIR_SEL_ADDR, 8'h04);
		for (int m = 0; m < 8; m++) wr(8'(8'h08 + m), 8'(8'h10 + m));
		for (int m = 0; m < 8; m++) rc(8'(8'h08 + m), 8'(8'h10 + m));
		wr(8'h03, 8'h5a);
		rc(8'h03, 8'h5a);
		wr(8'h04, 8'hff);
		rc(8'h04, 8'h4f);
		chk(outgoing_remote_flag, 16'h0001);
		// Busy is synchronised inside, so allow it to settle both ways
		tx_busy <= 6'h01;
		repeat (6) @(posedge sys_clk);
		wr(8'h08, 8'hee);
		rc(8'h08, 8'h10);
		tx_busy <= 6'h00;
		repeat (6) @(posedge sys_clk);
		wr(MODE_ADDR, 8'h00);
		wr(8'h09, 8'h77);
		wr(MODE_ADDR, 8'h02);
		rc(8'h09, 8'h11);
		pe.store(3'h1, XID, 1'b1, 1'b1, 4'h8, PAY);
		rc(8'h11, {XID[20:18], 3'h6, XID[17:16]});
		rc(8'h14, 8'h48);
		for (int m = 0; m < 8; m++) rc(8'(8'h18 + m), PAY[8*m +: 8]);
		wr(8'h18, 8'h00);
		rc(8'h18, PAY[7:0]);
		for (int k = 0; k < 4; k++) wr(8'(8'h9c + k), FB[k]);
		for (int k = 0; k < 4; k++) wr(8'(8'h80 + k), FB[k] & 8'hf7);
		for (int k = 0; k < 4; k++) rc(8'(8'h9c + k), FB[k]);
		check_id <= XID;
		check_extended <= 1'b1;
		repeat (2) @(posedge sys_clk);
		chk(filter_hit[7], 1'b1);
		chk(filter_hit[0], 1'b0);
		check_extended <= 1'b0;
		repeat (2) @(posedge sys_clk);
		chk(filter_hit[7], 1'b0);
		wr(MODE_ADDR, 8'h00);
		rc(8'h9c, 8'h00);
		rc(8'h80, FB[0]);
		for (int k = 0; k < 4; k++) wr(8'(8'h80 + k), FB[k]);
		check_extended <= 1'b1;
		repeat (2) @(posedge sys_clk);
		chk(filter_hit[0], 1'b1);
		chk(filter_hit[7], 1'b0);
		// Reset again mid-run: direction must drop back to receive
		reset_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		chk(buffer_direction_flag, 16'h0000);
		rc(DIR_SEL_ADDR, 8'h00);
		give_verdict();
	end
endmodule : tb_can_buf_regs
`default_nettype wire

// [common/can_buf_pkg.sv]
// Package for the programmable buffer and acceptance filter register block.
// Assumes one system clock and a simple strobe register port.
package can_buf_pkg;
	localparam int ADDR_W = 8;
	localparam int NUM_BUFS = 6;
	localparam int NUM_FILTERS = 16;
	localparam int NUM_BASE_FILTERS = 6;
	localparam int PAYLOAD_BYTES = 8;
	// Register map: buffer n occupies 16 bytes from BUF_BASE + 16*n
	localparam logic [7:0] BUF_BASE = 8'h00;
	localparam logic [3:0] BUF_SIDH_OFS = 4'h0;
	localparam logic [3:0] BUF_SIDL_OFS = 4'h1;
	localparam logic [3:0] BUF_EIDH_OFS = 4'h2;
	localparam logic [3:0] BUF_EIDL_OFS = 4'h3;
	localparam logic [3:0] BUF_DLC_OFS = 4'h4;
	localparam logic [3:0] BUF_DATA_OFS = 4'h8;
	localparam logic [7:0] DIR_SEL_ADDR = 8'h60;
	localparam logic [7:0] MODE_ADDR = 8'h61;
	localparam logic [7:0] BUSY_ADDR = 8'h62;
	// Filter n occupies 4 bytes from FLT_BASE + 4*n
	localparam logic [7:0] FLT_BASE = 8'h80;
	// Field layouts
	localparam logic [7:0] DIR_SEL_MASK = 8'hfc;
	localparam logic [7:0] SIDL_MASK = 8'he8;
	localparam logic [7:0] SIDL_RX_MASK = 8'heb;
	localparam logic [7:0] SIDL_TX_MASK = 8'heb;
	localparam logic [7:0] FLT_SIDL_MASK = 8'heb;
	localparam int EXT_BIT = 3;
	localparam int RTR_BIT = 6;
	localparam logic [7:0] DLC_RX_MASK = 8'h4f;
	localparam logic [7:0] DLC_TX_MASK = 8'h4f;
	localparam logic [7:0] DIR_SEL_RESET = 8'h00;
	localparam logic [1:0] MODE_RESET = 2'h0;
endpackage : can_buf_pkg

// [rtl/can_buf_regs.sv]
// Register file of six programmable transmit/receive buffers and sixteen acceptance filters.
// Assumes the protocol engine stores received frames and reports busy transmit buffers.
`timescale 1ns/1ns
`default_nettype none
module can_buf_regs
	import can_buf_pkg::*;
#(
	parameter int BUFS = NUM_BUFS,
	parameter int FILTERS = NUM_FILTERS
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	// Receive store from the protocol engine
	input wire logic rx_store,
	input wire logic [2:0] rx_buf_index,
	input wire logic [28:0] rx_id,
	input wire logic rx_extended,
	input wire logic rx_remote,
	input wire logic [3:0] rx_length,
	input wire logic [63:0] rx_payload,
	// Per-buffer send request or transmission in progress
	input wire logic [BUFS-1:0] tx_busy,
	// Frame offered for acceptance checking
	input wire logic [28:0] check_id,
	input wire logic check_extended,
	output logic [FILTERS-1:0] filter_hit,
	output logic [BUFS-1:0] buffer_direction_flag,
	output logic [BUFS-1:0] outgoing_remote_flag
);

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic [7:0] dir_sel_reg;
	logic [1:0] mode_reg;
	logic [7:0] sidh_reg [BUFS];
	logic [7:0] sidl_reg [BUFS];
	logic [7:0] eidh_reg [BUFS];
	logic [7:0] eidl_reg [BUFS];
	logic [7:0] dlc_reg [BUFS];
	logic [7:0] payload_reg [BUFS][PAYLOAD_BYTES];
	logic [7:0] fsidh_reg [FILTERS];
	logic [7:0] fsidl_reg [FILTERS];
	logic [7:0] feidh_reg [FILTERS];
	logic [7:0] feidl_reg [FILTERS];
	logic [7:0] rdata_next;
	logic buf_regs_on;
	logic [BUFS-1:0] tx_sync1_reg;
	logic [BUFS-1:0] tx_sync2_reg;
	logic [BUFS-1:0] tx_sync3_reg;
	logic [BUFS-1:0] busy_reg;

	assign buf_regs_on = (mode_reg == 2'd1) || (mode_reg == 2'd2);

	// ------------------------------------------------------------
	// Busy input crossing
	// ------------------------------------------------------------
	// The engine may run on its own clock, so busy is filtered: a change counts
	// only once the second and third stages agree.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_sync1_reg <= '0;
			tx_sync2_reg <= '0;
			tx_sync3_reg <= '0;
			busy_reg <= '0;
		end else begin
			tx_sync1_reg <= tx_busy;
			tx_sync2_reg <= tx_sync1_reg;
			tx_sync3_reg <= tx_sync2_reg;
			for (int i = 0; i < BUFS; i++) begin
				if (tx_sync2_reg[i] == tx_sync3_reg[i]) begin
					busy_reg[i] <= tx_sync3_reg[i];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			dir_sel_reg <= DIR_SEL_RESET;
			mode_reg <= MODE_RESET;
		end else if (reg_write) begin
			if (reg_addr == DIR_SEL_ADDR) begin
				dir_sel_reg <= reg_wdata & DIR_SEL_MASK;
			end
			if (reg_addr == MODE_ADDR) begin
				mode_reg <= reg_wdata[1:0];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			buffer_direction_flag <= '0;
			outgoing_remote_flag <= '0;
		end else begin
			for (int i = 0; i < BUFS; i++) begin
				buffer_direction_flag[i] <= dir_sel_reg[i+2];
				outgoing_remote_flag[i] <= dir_sel_reg[i+2] & dlc_reg[i][RTR_BIT];
			end
		end
	end

	// ------------------------------------------------------------
	// Buffers
	// ------------------------------------------------------------
	// Contents are not reset; only the direction is. Receive stores are only
	// accepted into buffers set to receive, so a software write and a store
	// can never target the same buffer in one cycle.
	genvar gb;
	generate
		for (gb = 0; gb < BUFS; gb++) begin : g_buf
			logic sw_ok;
			logic hit;
			logic [7:0] row;
			logic rx_here;
			assign row = BUF_BASE + 8'(gb * 16);
			assign hit = reg_write && buf_regs_on && (reg_addr[7:4] == row[7:4]);
			assign sw_ok = hit && dir_sel_reg[gb+2] && !busy_reg[gb];
			assign rx_here = rx_store && (rx_buf_index == 3'(gb)) && !dir_sel_reg[gb+2];
			always_ff @(posedge sys_clk) begin
				if (rx_here) begin
					if (rx_extended) begin
						sidh_reg[gb] <= rx_id[28:21];
						sidl_reg[gb] <= {rx_id[20:18], 1'b1, 1'b1, 1'b0, rx_id[17:16]};
						eidh_reg[gb] <= rx_id[15:8];
						eidl_reg[gb] <= rx_id[7:0];
					end else begin
						sidh_reg[gb] <= rx_id[10:3];
						sidl_reg[gb] <= {rx_id[2:0], rx_remote, 1'b0, 3'b000};
						eidh_reg[gb] <= 8'h00;
						eidl_reg[gb] <= 8'h00;
					end
					dlc_reg[gb] <= {1'b0, rx_remote, 2'b00, rx_length};
					for (int m = 0; m < PAYLOAD_BYTES; m++) begin
						payload_reg[gb][m] <= rx_payload[m*8 +: 8];
					end
				end else if (sw_ok) begin
					unique case (reg_addr[3:0])
						BUF_SIDH_OFS: sidh_reg[gb] <= reg_wdata;
						// Transmit low byte keeps id bits 7..5, the select bit and ext 17..16
						BUF_SIDL_OFS: sidl_reg[gb] <= reg_wdata & SIDL_TX_MASK;
						BUF_EIDH_OFS: eidh_reg[gb] <= reg_wdata;
						BUF_EIDL_OFS: eidl_reg[gb] <= reg_wdata;
						BUF_DLC_OFS: dlc_reg[gb] <= reg_wdata & DLC_TX_MASK;
						default: begin
							if (reg_addr[3]) begin
								payload_reg[gb][reg_addr[2:0]] <= reg_wdata;
							end
						end
					endcase
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Acceptance filters
	// ------------------------------------------------------------
	genvar gf;
	generate
		for (gf = 0; gf < FILTERS; gf++) begin : g_flt
			logic present;
			logic fhit;
			logic [7:0] row;
			logic [10:0] std_id;
			logic [28:0] ext_id;
			assign present = (gf < NUM_BASE_FILTERS) || buf_regs_on;
			assign row = FLT_BASE + 8'(gf * 4);
			assign fhit = reg_write && present && (reg_addr[7:2] == row[7:2]);
			assign std_id = {fsidh_reg[gf], fsidl_reg[gf][7:5]};
			assign ext_id = {fsidh_reg[gf], fsidl_reg[gf][7:5], fsidl_reg[gf][1:0],
				feidh_reg[gf], feidl_reg[gf]};
			always_ff @(posedge sys_clk) begin
				if (fhit) begin
					unique case (reg_addr[1:0])
						2'd0: fsidh_reg[gf] <= reg_wdata;
						2'd1: fsidl_reg[gf] <= reg_wdata & FLT_SIDL_MASK;
						2'd2: feidh_reg[gf] <= reg_wdata;
						2'd3: feidl_reg[gf] <= reg_wdata;
					endcase
				end
			end
			// Masks are outside this block, so the compare is exact on all bits
			always_ff @(posedge sys_clk or negedge reset_n) begin
				if (!reset_n) begin
					filter_hit[gf] <= 1'b0;
				end else if (!present) begin
					filter_hit[gf] <= 1'b0;
				end else if (fsidl_reg[gf][EXT_BIT]) begin
					filter_hit[gf] <= check_extended && (check_id == ext_id);
				end else begin
					filter_hit[gf] <= !check_extended && (check_id[10:0] == std_id);
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	// Unmapped or absent addresses read zero.
	always_comb begin
		rdata_next = 8'h00;
		if (reg_addr == DIR_SEL_ADDR) begin
			rdata_next = dir_sel_reg & DIR_SEL_MASK;
		end else if (reg_addr == MODE_ADDR) begin
			rdata_next = {6'h00, mode_reg};
		end else if (reg_addr == BUSY_ADDR) begin
			rdata_next = 8'(busy_reg);
		end else if (reg_addr < DIR_SEL_ADDR) begin
			if (buf_regs_on && (reg_addr[7:4] < 4'(BUFS))) begin
				unique case (reg_addr[3:0])
					BUF_SIDH_OFS: rdata_next = sidh_reg[reg_addr[6:4]];
					BUF_SIDL_OFS: rdata_next = sidl_reg[reg_addr[6:4]];
					BUF_EIDH_OFS: rdata_next = eidh_reg[reg_addr[6:4]];
					BUF_EIDL_OFS: rdata_next = eidl_reg[reg_addr[6:4]];
					BUF_DLC_OFS: rdata_next = dlc_reg[reg_addr[6:4]] & DLC_RX_MASK;
					default: begin
						if (reg_addr[3]) begin
							rdata_next = payload_reg[reg_addr[6:4]][reg_addr[2:0]];
						end
					end
				endcase
			end
		end else if (reg_addr >= FLT_BASE && reg_addr < FLT_BASE + 8'(FILTERS * 4)) begin
			if ((reg_addr[5:2] < 4'(NUM_BASE_FILTERS)) || buf_regs_on) begin
				unique case (reg_addr[1:0])
					2'd0: rdata_next = fsidh_reg[reg_addr[5:2]];
					2'd1: rdata_next = fsidl_reg[reg_addr[5:2]] & FLT_SIDL_MASK;
					2'd2: rdata_next = feidh_reg[reg_addr[5:2]];
					2'd3: rdata_next = feidl_reg[reg_addr[5:2]];
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_read) begin
			reg_rdata <= rdata_next;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

endmodule : can_buf_regs
`default_nettype wire
